// File: shared/sas_pkg.sv
// ****************************************
// converter sequencer constants
// ****************************************
package sas_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RESH = 8'h04;
    localparam logic [7:0] OFF_ISTAT = 8'h08;
    localparam logic [7:0] OFF_IMASK = 8'h0c;
    // control/status field positions
    localparam int CTRL_CHAN0 = 0;
    localparam int CTRL_CHAN1 = 1;
    localparam int CTRL_START = 3;
    localparam int CTRL_DONE = 4;
    localparam int CTRL_EXTEN = 5;
    localparam int CTRL_RES0 = 6;
    localparam int CTRL_RES1 = 7;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_W = 2;
    // sequence timing in machine cycles
    localparam int RES_BITS = 10;
    localparam int SAMPLE_CYCLES = 8;
    localparam int BIT_CYCLES = 4;
    localparam int DONE_AFTER_STATUS = 52;
    localparam int SETTLE_CYCLES =
        DONE_AFTER_STATUS - 1 - SAMPLE_CYCLES - RES_BITS * BIT_CYCLES;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] BIT_LAST = 4'(BIT_CYCLES - 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = 4'(SETTLE_CYCLES - 1);
    localparam logic [3:0] MSB_IDX = 4'(RES_BITS - 1);
    localparam logic [9:0] MSB_CODE = 10'h200;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // sequencer phases
    typedef enum logic [2:0] {
        ST_IDLE, ST_INIT1, ST_INIT2, ST_SAMPLE, ST_TRIAL, ST_SETTLE
    } sas_state_t;
endpackage : sas_pkg

// File: rtl/sas_sequencer.sv
// What this block does
// - writing one to the start bit begins a conversion.
// - software start works whatever the external trigger enable says.
// - with trigger enable set, a trigger pin rising edge starts conversion.
// - trigger edge seen at cycle end, conversion begins next cycle.
// - software start begins in the machine cycle after the write.
// - start bit is a command flip-flop plus a separate readable status flag.
// - two init cycles; status set after first, sampling after second.
// - selected input is sampled for eight machine cycles.
// - first trial loads only the top bit, kept if input above ladder.
// - each lower bit tried in turn, four machine cycles per bit.
// - done sets bit 4; top eight bits to high byte, low two to bits 7:6.
// - done set and status cleared 52 cycles after status set.
// - control bits 1:0 select one of four analog channels.
// - start requests during a conversion are ignored.
// - idle or power-down entry aborts a running conversion.
// - result stays unchanged while the done flag is set.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module sas_sequencer (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // axi4-lite write address
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    // axi4-lite write data
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // axi4-lite write response
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // axi4-lite read
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // processor power modes
    input wire logic idle_i,
    input wire logic power_down_i,
    // analog side
    input wire logic external_trigger_pin_i,
    input wire logic comparator_i,
    output logic [1:0] channel_select_o,
    output logic [9:0] ladder_code_o,
    output logic sampling_o,
    // interrupt
    output logic irq_o
);

    // ****************************************
    // state
    // ****************************************
    sas_pkg::sas_state_t state;
    logic [sas_pkg::CNT_W-1:0] cnt;
    logic [3:0] bit_idx;
    logic [9:0] sar;
    logic start_cmd;
    logic start_status;
    logic done;
    logic exten;
    logic [1:0] chan;
    logic [7:0] res_hi;
    logic [1:0] res_lo;
    logic [sas_pkg::IRQ_W-1:0] istat;
    logic [sas_pkg::IRQ_W-1:0] imask;
    logic trig_s1, trig_s2, trig_s3;
    logic comp_s1, comp_s2;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;

    // ****************************************
    // decode helpers
    // ****************************************
    // one-hot register select, shared by read and write paths
    function automatic logic [3:0] reg_sel(input logic [7:0] a);
        reg_sel = {a == sas_pkg::OFF_IMASK, a == sas_pkg::OFF_ISTAT,
                   a == sas_pkg::OFF_RESH, a == sas_pkg::OFF_CTRL};
    endfunction : reg_sel

    logic wr_fire;
    logic [3:0] wsel;
    logic ctrl_wr;
    logic abort;
    logic trig_rise;
    logic sw_start;
    logic start_req;
    logic can_start;
    logic finish;
    logic ar_fire;
    logic [3:0] rsel;
    logic [7:0] ctrl_view;

    assign wr_fire = ce_i && aw_held && w_held && !bvalid;
    assign wsel = reg_sel(aw_addr);
    assign ctrl_wr = wr_fire && wsel[0] && w_lane0;
    assign abort = idle_i || power_down_i;
    assign trig_rise = trig_s2 && !trig_s3;
    // start bit write of one, independent of the trigger enable
    assign sw_start = ctrl_wr && w_byte[sas_pkg::CTRL_START];
    assign start_req = sw_start || (exten && trig_rise);
    // busy or a held result blocks new starts
    assign can_start = (state == sas_pkg::ST_IDLE) && !start_cmd && !done && !abort;
    assign finish = (state == sas_pkg::ST_SETTLE) && (cnt == sas_pkg::SETTLE_LAST);
    assign ar_fire = ce_i && s_axi_arvalid_i && !rvalid;
    assign rsel = reg_sel(s_axi_araddr_i[7:0]);
    assign ctrl_view = {res_lo, exten, done, start_status, 1'b0, chan};

    // ****************************************
    // pin synchronisers
    // ****************************************
    // pulse of two cycles or more survives the two-stage sync
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
            comp_s1 <= 1'b0;
            comp_s2 <= 1'b0;
        end else if (ce_i) begin
            trig_s1 <= external_trigger_pin_i;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            comp_s1 <= comparator_i;
            comp_s2 <= comp_s1;
        end
    end

    // ****************************************
    // start command flip-flop
    // ****************************************
    // command half of the start bit; never read back by software
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            start_cmd <= 1'b0;
        end else if (ce_i) begin
            if (abort) begin
                start_cmd <= 1'b0;
            end else if (start_req && can_start) begin
                start_cmd <= 1'b1;
            end else if (state == sas_pkg::ST_IDLE) begin
                start_cmd <= 1'b0;
            end
        end
    end

    // ****************************************
    // conversion sequencer
    // ****************************************
    // one clk_i cycle with ce_i high is one machine cycle
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state <= sas_pkg::ST_IDLE;
            cnt <= '0;
            bit_idx <= '0;
            sar <= '0;
        end else if (ce_i) begin
            if (abort) begin
                state <= sas_pkg::ST_IDLE;
                cnt <= '0;
            end else begin
                unique case (state)
                    sas_pkg::ST_IDLE: begin
                        if (start_cmd) begin
                            state <= sas_pkg::ST_INIT1;
                        end
                    end
                    sas_pkg::ST_INIT1: begin
                        state <= sas_pkg::ST_INIT2;
                    end
                    sas_pkg::ST_INIT2: begin
                        state <= sas_pkg::ST_SAMPLE;
                        cnt <= '0;
                    end
                    sas_pkg::ST_SAMPLE: begin
                        if (cnt == sas_pkg::SAMPLE_LAST) begin
                            state <= sas_pkg::ST_TRIAL;
                            cnt <= '0;
                            bit_idx <= sas_pkg::MSB_IDX;
                            sar <= sas_pkg::MSB_CODE;
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                    sas_pkg::ST_TRIAL: begin
                        if (cnt == sas_pkg::BIT_LAST) begin
                            // comparator has had two cycles to settle through sync
                            cnt <= '0;
                            if (!comp_s2) begin
                                sar[bit_idx] <= 1'b0;
                            end
                            if (bit_idx == 4'h0) begin
                                state <= sas_pkg::ST_SETTLE;
                            end else begin
                                bit_idx <= bit_idx - 1'b1;
                                sar[bit_idx - 1'b1] <= 1'b1;
                            end
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                    sas_pkg::ST_SETTLE: begin
                        if (finish) begin
                            state <= sas_pkg::ST_IDLE;
                            cnt <= '0;
                        end else begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // start status flag
    // ****************************************
    // readable half of the start bit
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            start_status <= 1'b0;
        end else if (ce_i) begin
            if (abort || finish) begin
                start_status <= 1'b0;
            end else if (state == sas_pkg::ST_INIT1) begin
                start_status <= 1'b1;
            end
        end
    end

    // ****************************************
    // done flag and result
    // ****************************************
    // completion wins over a same-cycle software clear
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            done <= 1'b0;
            res_hi <= '0;
            res_lo <= '0;
        end else if (ce_i) begin
            if (finish && !abort) begin
                done <= 1'b1;
                res_hi <= sar[9:2];
                res_lo <= sar[1:0];
            end else if (ctrl_wr && !w_byte[sas_pkg::CTRL_DONE]) begin
                done <= 1'b0;
            end
        end
    end

    // ****************************************
    // software control fields
    // ****************************************
    // channel changes reach channel_select_o the cycle after the write, even mid-conversion
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            exten <= 1'b0;
            chan <= '0;
        end else if (ce_i && ctrl_wr) begin
            exten <= w_byte[sas_pkg::CTRL_EXTEN];
            chan <= w_byte[sas_pkg::CTRL_CHAN1:sas_pkg::CTRL_CHAN0];
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    // write one clears, but a fresh event in that cycle stays set
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            istat <= '0;
            imask <= '0;
        end else if (ce_i) begin
            istat <= (istat & ~((wr_fire && wsel[2] && w_lane0) ? w_byte[1:0] : 2'h0))
                | {abort && (state != sas_pkg::ST_IDLE), finish};
            if (wr_fire && wsel[3] && w_lane0) begin
                imask <= w_byte[1:0];
            end
        end
    end

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    // address and data taken in either order; response after both
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= '0;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= sas_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_awvalid_i && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i[7:0];
            end
            if (s_axi_wvalid_i && !w_held) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata_i[7:0];
                w_lane0 <= s_axi_wstrb_i[0];
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                // result byte is read only; writes to it are refused
                bresp <= (wsel[0] || wsel[2] || wsel[3]) ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
            end else if (bvalid && s_axi_bready_i) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= sas_pkg::RESP_OKAY;
        end else if (ce_i) begin
            if (ar_fire) begin
                rvalid <= 1'b1;
                rresp <= (rsel != 4'h0) ? sas_pkg::RESP_OKAY : sas_pkg::RESP_SLVERR;
                unique case (1'b1)
                    rsel[0]: rdata <= {24'h0, ctrl_view};
                    rsel[1]: rdata <= {24'h0, res_hi};
                    rsel[2]: rdata <= {30'h0, istat};
                    rsel[3]: rdata <= {30'h0, imask};
                    default: rdata <= '0;
                endcase
            end else if (rvalid && s_axi_rready_i) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready_o = ce_i && !aw_held;
    assign s_axi_wready_o = ce_i && !w_held;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_arready_o = ce_i && !rvalid;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;
    assign channel_select_o = chan;
    assign ladder_code_o = sar;
    assign sampling_o = (state == sas_pkg::ST_SAMPLE);
    assign irq_o = |(istat & imask);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i || !ce_i);

    sequence s_sampling8;
        sampling_o [*8];
    endsequence

    sequence s_one_bit;
        (state == sas_pkg::ST_TRIAL && cnt == 4'h0) ##3 (state == sas_pkg::ST_TRIAL && cnt == 4'h3);
    endsequence

    property p_sw_start;
        sw_start && can_start |=> start_cmd;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("software start not taken");

    property p_ext_start;
        exten && trig_rise && can_start |=> start_cmd;
    endproperty
    a_ext_start: assert property (p_ext_start) else $error("trigger edge not taken");

    property p_commence;
        start_cmd && state == sas_pkg::ST_IDLE && !abort |=> state == sas_pkg::ST_INIT1 ##1 start_status;
    endproperty
    // an abort during the init phase legally stops the status flag
    a_commence: assert property (disable iff (reset_i || !ce_i || abort) p_commence)
        else $error("conversion did not commence");

    property p_sample8;
        state == sas_pkg::ST_INIT2 && !abort |=> s_sampling8 ##1 (state == sas_pkg::ST_TRIAL);
    endproperty
    a_sample8: assert property (disable iff (reset_i || !ce_i || abort) p_sample8)
        else $error("sampling not eight cycles");

    property p_msb;
        sampling_o ##1 (state == sas_pkg::ST_TRIAL) |-> ladder_code_o == sas_pkg::MSB_CODE;
    endproperty
    a_msb: assert property (p_msb) else $error("first trial code wrong");

    property p_bit4;
        state == sas_pkg::ST_TRIAL && cnt == 4'h0 && !abort |-> s_one_bit;
    endproperty
    a_bit4: assert property (disable iff (reset_i || !ce_i || abort) p_bit4)
        else $error("bit trial not four cycles");

    property p_done52;
        $rose(start_status) |-> ##52 (done && !start_status);
    endproperty
    a_done52: assert property (disable iff (reset_i || !ce_i || abort) p_done52)
        else $error("done not 52 cycles after start");

    property p_result;
        $rose(done) |-> res_hi == $past(sar[9:2]) && res_lo == $past(sar[1:0]);
    endproperty
    a_result: assert property (p_result) else $error("result not placed");

    property p_ignore;
        // a start taken while busy would show up as a raised command bit
        (state != sas_pkg::ST_IDLE) && start_req |=> !start_cmd;
    endproperty
    a_ignore: assert property (p_ignore) else $error("start during conversion");

    property p_abort;
        abort && state != sas_pkg::ST_IDLE |=> state == sas_pkg::ST_IDLE && !start_status;
    endproperty
    a_abort: assert property (p_abort) else $error("abort not honoured");

    property p_hold;
        done ##1 done |-> $stable(res_hi) && $stable(res_lo);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed while done");

endmodule : sas_sequencer

// File: tb/sas_analog_model.sv
`timescale 1ns/1ps
// ****************************************
// analog inputs and trigger source
// ****************************************
module sas_analog_model (
    // clock
    input wire logic clk_i,
    // from the sequencer
    input wire logic [1:0] channel_select_i,
    input wire logic [9:0] ladder_code_i,
    // to the sequencer
    output logic comparator_o,
    output logic external_trigger_pin_o
);
    // input levels per channel, chosen to hit the all-zero code and the 3fe code
    logic [9:0] level [4] = '{10'h2a5, 10'h000, 10'h3ff, 10'h155};

    // comparator high while the selected input is above the ladder
    assign comparator_o = level[channel_select_i] > ladder_code_i;

    // pin rests low between pulses
    initial external_trigger_pin_o = 1'b0;

    // symmetrical pulse: high n cycles, then low n cycles
    task automatic pulse(input int n);
        @(posedge clk_i);
        external_trigger_pin_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        external_trigger_pin_o <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask : pulse
endmodule : sas_analog_model

// File: tb/test_sas_sequencer.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module test_sas_sequencer;
    typedef struct {logic [1:0] ch; logic ex; logic [9:0] res;} sas_row_t;
    logic clk, rst, ce, awv, wv, bre, arv, rre, idle, pdn, trig, cmp;
    logic awr, wrdy, bv, arr, rv, samp, irq;
    logic [31:0] awa, wd, ara, rd, d;
    logic [1:0] br, rr, chan, r;
    logic [9:0] code;
    int failures = 0, check_count = 0, s, t;
    // channel, trigger enable, expected code
    sas_row_t rows [4] = '{'{2'h0, 1'b0, 10'h2a4}, '{2'h1, 1'b0, 10'h000},
                           '{2'h2, 1'b1, 10'h3fe}, '{2'h3, 1'b1, 10'h154}};

    sas_sequencer dut (.clk_i(clk), .reset_i(rst), .ce_i(ce),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_awprot_i(3'h0),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h1),
        .s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_bresp_o(br),
        .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
        .idle_i(idle), .power_down_i(pdn), .external_trigger_pin_i(trig), .comparator_i(cmp),
        .channel_select_o(chan), .ladder_code_o(code), .sampling_o(samp), .irq_o(irq));
    sas_analog_model m (.clk_i(clk), .channel_select_i(chan), .ladder_code_i(code),
        .comparator_o(cmp), .external_trigger_pin_o(trig));

    // free running clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ****************************************
    // bus and timing helpers
    // ****************************************
    // sampled mid-cycle so combinational readies are settled
    task automatic await(ref logic x);
        @(negedge clk);
        while (!x) @(negedge clk);
    endtask : await

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic pa, pw, ga, gw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awa <= {24'h0, a};
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        // each channel released on its own handshake
        while (pa || pw) begin
            @(negedge clk);
            ga = awr;
            gw = wrdy;
            @(posedge clk);
            pa = pa & ~ga;
            pw = pw & ~gw;
            awv <= pa;
            wv <= pw;
        end
        await(bv);
        resp = br;
        @(posedge clk);
        bre <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge clk);
        ara <= {24'h0, a};
        arv <= 1'b1;
        rre <= 1'b1;
        await(arr);
        @(posedge clk);
        arv <= 1'b0;
        await(rv);
        v = rd;
        resp = rr;
        @(posedge clk);
        rre <= 1'b0;
    endtask : rdr

    // sampling cycles, and cycles from first sample to done interrupt
    task automatic run_conv(output int sc, output int tc);
        sc = 0;
        tc = 0;
        await(samp);
        while (!irq) begin
            sc += int'(samp);
            tc++;
            @(negedge clk);
        end
    endtask : run_conv

    task automatic quiet(input int n, output int c);
        c = 0;
        repeat (n) begin
            @(negedge clk);
            c += int'(samp);
        end
    endtask : quiet

    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // a hang costs far more than the ~1000 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        {awv, wv, bre, arv, rre, idle, pdn} = '0;
        {awa, wd, ara} = '0;
        rst = 1'b1;
        ce = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wr(sas_pkg::OFF_IMASK, 32'h3, r);
        // ordinary conversions, one per channel
        for (int i = 0; i < 4; i++) begin
            wr(sas_pkg::OFF_CTRL, {26'h0, rows[i].ex, 3'h0, rows[i].ch}, r);
            wr(sas_pkg::OFF_ISTAT, 32'h3, r);
            wr(sas_pkg::OFF_CTRL, {26'h0, rows[i].ex, 3'h2, rows[i].ch}, r);
            run_conv(s, t);
            `CHK("sample cycles", 8, s)
            `CHK("done latency", 51, t)
            `CHK("channel", rows[i].ch, chan)
            rdr(sas_pkg::OFF_CTRL, d, r);
            `CHK("control", {24'h0, rows[i].res[1:0], rows[i].ex, 3'h4, rows[i].ch}, d)
            rdr(sas_pkg::OFF_RESH, d, r);
            `CHK("result high", {24'h0, rows[i].res[9:2]}, d)
        end
        // second start mid-conversion changes nothing; status reads one
        wr(sas_pkg::OFF_CTRL, 32'h1, r);
        wr(sas_pkg::OFF_ISTAT, 32'h3, r);
        wr(sas_pkg::OFF_CTRL, 32'h9, r);
        fork
            run_conv(s, t);
            begin
                repeat (20) @(posedge clk);
                wr(sas_pkg::OFF_CTRL, 32'h9, r);
                rdr(sas_pkg::OFF_CTRL, d, r);
            end
        join
        `CHK("restart ignored", 51, t)
        `CHK("start status", 1'b1, d[3])
        // a queued restart would have raised the status flag again by now
        rdr(sas_pkg::OFF_CTRL, d, r);
        `CHK("no queued restart", 32'h11, d)
        // pin start with trigger enabled, then disabled
        wr(sas_pkg::OFF_CTRL, 32'h23, r);
        wr(sas_pkg::OFF_ISTAT, 32'h3, r);
        fork
            run_conv(s, t);
            m.pulse(2);
        join
        `CHK("pin done latency", 51, t)
        rdr(sas_pkg::OFF_RESH, d, r);
        `CHK("pin result", 32'h55, d)
        wr(sas_pkg::OFF_CTRL, 32'h03, r);
        fork
            quiet(80, s);
            m.pulse(3);
        join
        `CHK("pin ignored", 0, s)
        // clock enable low for ten cycles stretches a conversion by ten
        wr(sas_pkg::OFF_ISTAT, 32'h3, r);
        wr(sas_pkg::OFF_CTRL, 32'h0b, r);
        fork
            run_conv(s, t);
            begin
                repeat (20) @(posedge clk);
                ce <= 1'b0;
                repeat (10) @(posedge clk);
                ce <= 1'b1;
            end
        join
        `CHK("frozen sample cycles", 8, s)
        `CHK("frozen latency", 61, t)
        // idle entry with done set leaves result and flag alone
        @(posedge clk);
        idle <= 1'b1;
        @(posedge clk);
        idle <= 1'b0;
        rdr(sas_pkg::OFF_CTRL, d, r);
        `CHK("done kept in idle", 32'h13, d)
        // idle, then power-down, during sampling
        for (int k = 0; k < 2; k++) begin
            wr(sas_pkg::OFF_CTRL, 32'h0, r);
            wr(sas_pkg::OFF_ISTAT, 32'h3, r);
            wr(sas_pkg::OFF_CTRL, 32'h8, r);
            await(samp);
            @(posedge clk);
            idle <= (k == 0);
            pdn <= (k == 1);
            @(posedge clk);
            idle <= 1'b0;
            pdn <= 1'b0;
            quiet(70, s);
            `CHK("aborted", 0, s)
            rdr(sas_pkg::OFF_ISTAT, d, r);
            `CHK("abort event", 32'h2, d)
            rdr(sas_pkg::OFF_RESH, d, r);
            `CHK("result kept", 32'h55, d)
        end
        // mask and clear the pending abort event
        `CHK("irq set", 1'b1, irq)
        wr(sas_pkg::OFF_IMASK, 32'h0, r);
        @(negedge clk);
        `CHK("irq masked", 1'b0, irq)
        wr(sas_pkg::OFF_IMASK, 32'h3, r);
        wr(sas_pkg::OFF_ISTAT, 32'h2, r);
        @(negedge clk);
        `CHK("irq cleared", 1'b0, irq)
        // mid-run reset, then reset values and unmapped places
        @(posedge clk);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 20; a += 4) begin
            rdr(8'(a), d, r);
            `CHK("reset value", 32'h0, d)
            `CHK("read resp", (a == 16) ? sas_pkg::RESP_SLVERR : sas_pkg::RESP_OKAY, r)
        end
        wr(sas_pkg::OFF_RESH, 32'hff, r);
        `CHK("read-only write", sas_pkg::RESP_SLVERR, r)
        report_and_stop();
    end
endmodule : test_sas_sequencer
